// File: include/o8t_consts.vh
// Function
// - Eight-bit up-counter, readable by software anytime
// - Repeat mode: match clears counter, raises event
// - One-shot mode: match clears counter, then stops
// - Halted CPU: no one-shot automatic stop
// - Division select 0..5 gives divide 1..32
// - Clock feed enable bit gates divided clock
// - Writing clear bit forces counter to zero
// - Counter also compared with duty value
// - Run bit starts, stop keeps counter value
// - Run plus clear together: clear, then count
// - PWM high above duty, low after match
// - Match sets flag; enable gates request; W1C, also cleared by a read
//
// Purpose: constants of the 8-bit low-speed-oscillator timer
// Assumes: register indices times four give AXI byte addresses
// Notes: definitions only
`ifndef O8T_CONSTS_VH
`define O8T_CONSTS_VH

`define O8T_ADDR_W 20
`define O8T_IDX_FEED 20'h05065
`define O8T_IDX_CTL 20'h050c0
`define O8T_IDX_CNT 20'h050c1
`define O8T_IDX_CMP 20'h050c2
`define O8T_IDX_IMSK 20'h050c3
`define O8T_IDX_IFLG 20'h050c4
`define O8T_IDX_DUTY 20'h050c5

`define O8T_FEED_EN_BIT 0
`define O8T_FEED_DIV_LSB 1
`define O8T_FEED_DIV_MSB 3
`define O8T_CTL_RUN_BIT 0
`define O8T_CTL_MODE_BIT 1
`define O8T_CTL_CLR_BIT 4
`define O8T_FLAG_BIT 0

`define O8T_DIV_RESET 3'h0
`define O8T_DIV_MAX 3'h5
`define O8T_BYTE_RESET 8'h00
`define O8T_PRE_W 5

`define O8T_RESP_OKAY 2'h0
`define O8T_RESP_SLVERR 2'h2

`endif

// File: logic/o8t_timer.v
// Purpose: 8-bit up-counting timer with compare, PWM and interrupt
// Assumes: core_clk 20 MHz; oscillator pin slower than core_clk / 2
// Notes: AXI4-Lite slave; one write and one read in flight at a time
`timescale 1ns/10ps
`default_nettype none
`include "o8t_consts.vh"

module o8t_timer
(
    input wire core_clk,
    input wire resetn,
    input wire low_speed_oscillator,
    input wire cpu_halt,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg pwm_output_pin,
    output reg interrupt_request
);

    // ****************************************
    // Oscillator sampling and division
    // ****************************************
    reg osc_s1_reg;
    reg osc_s2_reg;
    reg osc_s3_reg;
    reg [`O8T_PRE_W-1:0] pre_reg;
    reg clock_feed_enable;
    reg [2:0] clock_division_select;
    wire osc_edge;
    wire [`O8T_PRE_W-1:0] div_mask;
    wire count_tick;

    assign osc_edge = osc_s2_reg & ~osc_s3_reg;
    assign div_mask = (5'h01 << clock_division_select) - 5'h01;
    // Reserved division codes give no tick at all
    assign count_tick = osc_edge & clock_feed_enable
        & ((pre_reg & div_mask) == div_mask)
        & (clock_division_select <= `O8T_DIV_MAX);

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
            pre_reg <= {`O8T_PRE_W{1'b0}};
        end
        else
        begin
            osc_s1_reg <= low_speed_oscillator;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
            // Prescaler idles with the feed off to save power
            if (!clock_feed_enable)
                pre_reg <= {`O8T_PRE_W{1'b0}};
            else if (osc_edge)
                pre_reg <= pre_reg + 5'h01;
        end
    end

    // ****************************************
    // Bus decode
    // ****************************************
    wire [`O8T_ADDR_W-1:0] wr_idx;
    wire [`O8T_ADDR_W-1:0] rd_idx;
    wire wr_fire;
    wire rd_fire;
    wire wr_lane;
    wire [7:0] wb;
    wire wr_feed;
    wire wr_ctl;
    wire wr_cmp;
    wire wr_imsk;
    wire wr_iflg;
    wire wr_duty;
    wire wr_hit;
    wire rd_hit;

    assign wr_idx = s_axi_awaddr[`O8T_ADDR_W+1:2];
    assign rd_idx = s_axi_araddr[`O8T_ADDR_W+1:2];
    assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
        & ~s_axi_bvalid;
    assign rd_fire = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    assign wr_lane = wr_fire & s_axi_wstrb[0];
    assign wb = s_axi_wdata[7:0];
    assign wr_feed = wr_lane & (wr_idx == `O8T_IDX_FEED);
    assign wr_ctl = wr_lane & (wr_idx == `O8T_IDX_CTL);
    assign wr_cmp = wr_lane & (wr_idx == `O8T_IDX_CMP);
    assign wr_imsk = wr_lane & (wr_idx == `O8T_IDX_IMSK);
    assign wr_iflg = wr_lane & (wr_idx == `O8T_IDX_IFLG);
    assign wr_duty = wr_lane & (wr_idx == `O8T_IDX_DUTY);
    assign wr_hit = (wr_idx == `O8T_IDX_FEED) | (wr_idx == `O8T_IDX_CTL)
        | (wr_idx == `O8T_IDX_CNT) | (wr_idx == `O8T_IDX_CMP)
        | (wr_idx == `O8T_IDX_IMSK) | (wr_idx == `O8T_IDX_IFLG)
        | (wr_idx == `O8T_IDX_DUTY);
    assign rd_hit = (rd_idx == `O8T_IDX_FEED) | (rd_idx == `O8T_IDX_CTL)
        | (rd_idx == `O8T_IDX_CNT) | (rd_idx == `O8T_IDX_CMP)
        | (rd_idx == `O8T_IDX_IMSK) | (rd_idx == `O8T_IDX_IFLG)
        | (rd_idx == `O8T_IDX_DUTY);

    // ****************************************
    // Timer core
    // ****************************************
    reg run_stop_bit;
    reg count_mode_select;
    reg [7:0] counter_value_reg;
    reg [7:0] compare_value_reg;
    reg [7:0] duty_value_reg;
    reg compare_event_enable;
    reg compare_event_flag;
    wire counter_clear;
    wire match;
    wire flag_clear;
    wire flag_next;

    assign counter_clear = wr_ctl & wb[`O8T_CTL_CLR_BIT];
    // Single clock: the count tick is an enable, so controls and
    // counter live in one domain and need no resynchronising
    assign match = count_tick & run_stop_bit & ~counter_clear
        & (counter_value_reg == compare_value_reg);
    assign flag_clear = (wr_iflg & wb[`O8T_FLAG_BIT])
        | (rd_fire & (rd_idx == `O8T_IDX_IFLG));
    // A match in the clearing cycle keeps the flag set
    assign flag_next = match | (compare_event_flag & ~flag_clear);

    // A halted CPU keeps a one-shot count running
    wire oneshot_stop;
    assign oneshot_stop = match & count_mode_select & ~cpu_halt;

    // ****************************************
    // Configuration registers
    // ****************************************
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            clock_feed_enable <= 1'b0;
            clock_division_select <= `O8T_DIV_RESET;
            compare_value_reg <= `O8T_BYTE_RESET;
            duty_value_reg <= `O8T_BYTE_RESET;
            compare_event_enable <= 1'b0;
        end
        else
        begin
            // Counter index is read-only: writes are answered, then dropped
            if (wr_feed)
            begin
                clock_feed_enable <= wb[`O8T_FEED_EN_BIT];
                clock_division_select <=
                    wb[`O8T_FEED_DIV_MSB:`O8T_FEED_DIV_LSB];
            end
            if (wr_cmp)
                compare_value_reg <= wb;
            if (wr_duty)
                duty_value_reg <= wb;
            if (wr_imsk)
                compare_event_enable <= wb[`O8T_FLAG_BIT];
        end
    end

    // ****************************************
    // Run control and counter
    // ****************************************
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            run_stop_bit <= 1'b0;
            count_mode_select <= 1'b0;
            counter_value_reg <= `O8T_BYTE_RESET;
        end
        else
        begin
            // Software write beats the one-shot stop in one cycle
            if (wr_ctl)
            begin
                run_stop_bit <= wb[`O8T_CTL_RUN_BIT];
                count_mode_select <= wb[`O8T_CTL_MODE_BIT];
            end
            else if (oneshot_stop)
                run_stop_bit <= 1'b0;
            // Clear wins over a tick; run from the same write counts
            // from zero on the next tick
            if (counter_clear)
                counter_value_reg <= `O8T_BYTE_RESET;
            else if (match)
                counter_value_reg <= `O8T_BYTE_RESET;
            else if (count_tick & run_stop_bit)
                counter_value_reg <= counter_value_reg + 8'h01;
        end
    end

    // ****************************************
    // Event flag, interrupt and PWM
    // ****************************************
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            compare_event_flag <= 1'b0;
            interrupt_request <= 1'b0;
            pwm_output_pin <= 1'b0;
        end
        else
        begin
            // Counter never passes compare, so duty above it keeps low
            pwm_output_pin <= (counter_value_reg > duty_value_reg);
            compare_event_flag <= flag_next;
            // Irq lags an enable write by one cycle
            interrupt_request <= flag_next & compare_event_enable;
        end
    end

    // ****************************************
    // AXI4-Lite handshake
    // ****************************************
    reg [7:0] rd_byte;

    always @*
    begin
        rd_byte = 8'h00;
        case (rd_idx)
            `O8T_IDX_FEED: rd_byte = {4'h0, clock_division_select,
                clock_feed_enable};
            `O8T_IDX_CTL: rd_byte = {6'h00, count_mode_select,
                run_stop_bit};
            `O8T_IDX_CNT: rd_byte = counter_value_reg;
            `O8T_IDX_CMP: rd_byte = compare_value_reg;
            `O8T_IDX_IMSK: rd_byte = {7'h00, compare_event_enable};
            `O8T_IDX_IFLG: rd_byte = {7'h00, compare_event_flag};
            `O8T_IDX_DUTY: rd_byte = duty_value_reg;
            default: rd_byte = 8'h00;
        endcase
    end

    // ****************************************
    // Write channel
    // ****************************************
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `O8T_RESP_OKAY;
        end
        else
        begin
            // Ready pulses after the take, so a held valid never re-fires
            s_axi_awready <= wr_fire;
            s_axi_wready <= wr_fire;
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `O8T_RESP_OKAY : `O8T_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `O8T_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end
        else
        begin
            s_axi_arready <= rd_fire;
            if (rd_fire)
            begin
                // Data is captured at the take and held until rready
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_hit ? `O8T_RESP_OKAY : `O8T_RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // o8t_timer
`default_nettype wire

// File: testbench/o8t_timer_checker.sv
// Purpose: port checks of the 8-bit timer
// Assumes: one clock, reset active low
// Notes: bound to the top module
`timescale 1ns/10ps
`default_nettype none
`include "o8t_consts.vh"
module o8t_timer_checker
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic interrupt_request
);
// ****
// Bus
// ****
default clocking cb @(posedge core_clk);
endclocking
default disable iff (!resetn);
sequence s_wr_req;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
endsequence
sequence s_wr_ans;
    s_axi_awready && s_axi_wready && s_axi_bvalid;
endsequence
property p_wr_ans; s_wr_req |=> s_wr_ans; endproperty
a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
property p_rd_ans;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
        |=> s_axi_arready && s_axi_rvalid;
endproperty
a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
property p_b_end; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
a_b_end: assert property (p_b_end) else $error("bvalid stuck");
property p_r_end; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
a_r_end: assert property (p_r_end) else $error("rvalid stuck");
property p_pulse; s_axi_awready |=> !s_axi_awready; endproperty
a_pulse: assert property (p_pulse) else $error("awready too long");
property p_ar_pulse; s_axi_arready |=> !s_axi_arready; endproperty
a_ar_pulse: assert property (p_ar_pulse) else $error("arready too long");
property p_byte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
a_byte: assert property (p_byte) else $error("upper read bits set");
property p_unmap;
    s_axi_arvalid && !s_axi_rvalid && s_axi_araddr[21:2] > `O8T_IDX_DUTY
        |=> s_axi_rresp == `O8T_RESP_SLVERR && s_axi_rdata == 32'h0;
endproperty
a_unmap: assert property (p_unmap) else $error("unmapped read ok");
// Irq may only drop as a result of a register access
property p_irq_fall;
    $fell(interrupt_request) |-> s_axi_bvalid || s_axi_rvalid
        || $past(s_axi_bvalid) || $past(s_axi_rvalid);
endproperty
a_irq_fall: assert property (p_irq_fall) else $error("irq lost");
endmodule // o8t_timer_checker
bind o8t_timer o8t_timer_checker u_chk
(
    .core_clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .interrupt_request
);
`default_nettype wire

// File: testbench/o8t_timer_test.sv
// Purpose: self-checking bench of the 8-bit timer
// Assumes: oscillator pin period of 8 core cycles
// Notes: tick counts allow one tick of slack for sync phase
`timescale 1ns/10ps
`default_nettype none
`include "o8t_consts.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
$display("mismatch %s exp %0h got %0h", n, e, g); end end
module o8t_timer_test;
// *****
// Bench
// *****
logic core_clk = 0, resetn = 0, halt = 0, k;
logic awv = 0, wv = 0, arv = 0, bry = 0, rry = 0;
logic awr, wr, bv, arr, rv, pwm, irq;
logic [2:0] osc = 0, g;
logic [31:0] awa = 0, wd = 0, ara = 0, rdat;
logic [1:0] brs, rrs, rs;
logic [7:0] rb;
int fails = 0;
int tests_run = 0;
o8t_timer dut
(
    .core_clk(core_clk), .resetn(resetn), .low_speed_oscillator(osc[2]),
    .cpu_halt(halt), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(brs),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .pwm_output_pin(pwm), .interrupt_request(irq)
);
initial forever #25 core_clk = ~core_clk;
always @(posedge core_clk) osc <= osc + 3'h1;
// Samples at negedge so handshake values never race the edge
task automatic bus(input logic w, input logic [19:0] i, input logic [7:0] d);
    @(posedge core_clk);
    awa <= {10'h0, i, 2'h0};
    ara <= {10'h0, i, 2'h0};
    wd <= {24'h0, d};
    {awv, wv, bry, arv, rry} <= {w, w, w, !w, !w};
    do
    begin
        @(negedge core_clk);
        g = {awr, wr, arr};
        k = w ? bv : rv;
        {rb, rs} = {rdat[7:0], w ? brs : rrs};
        @(posedge core_clk);
        {awv, wv, arv} <= {awv, wv, arv} & ~g;
    end
    while (k !== 1'b1);
    {bry, rry} <= 2'h0;
endtask
task automatic chk(input logic [19:0] i, input logic [7:0] e, logic [1:0] r);
    bus(0, i, 8'h00);
    `CHK("rresp", r, rs)
    `CHK("rdata", e, rb)
endtask
task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
endtask
task automatic t_regs;
    for (int n = 0; n < 7; n++)
        chk(n == 6 ? `O8T_IDX_FEED : `O8T_IDX_CTL + 20'(n),
            8'h00, 2'h0);
    chk(`O8T_IDX_DUTY + 20'h1, 8'h00, 2'h2);
    bus(1, `O8T_IDX_DUTY + 20'h1, 8'h5a);
    `CHK("bresp", 2'h2, rs)
    bus(1, `O8T_IDX_DUTY, 8'ha5);
    `CHK("bresp", 2'h0, rs)
    chk(`O8T_IDX_DUTY, 8'ha5, 2'h0);
    $display("end regs");
endtask
task automatic t_rep;
    logic [3:0] seen;
    logic [7:0] hold;
    seen = 4'h0;
    bus(1, `O8T_IDX_FEED, 8'h01);
    bus(1, `O8T_IDX_CMP, 8'h02);
    bus(1, `O8T_IDX_CTL, 8'h11);
    repeat (24)
    begin
        bus(0, `O8T_IDX_CNT, 8'h00);
        seen[rb[1:0]] = 1'b1;
    end
    `CHK("seen", 4'h7, seen)
    bus(1, `O8T_IDX_CTL, 8'h00);
    bus(0, `O8T_IDX_CNT, 8'h00);
    hold = rb;
    wt(40);
    chk(`O8T_IDX_CNT, hold, 2'h0);
    chk(`O8T_IDX_IFLG, 8'h01, 2'h0);
    bus(1, `O8T_IDX_CTL, 8'h10);
    chk(`O8T_IDX_CNT, 8'h00, 2'h0);
    $display("end repeat");
endtask
task automatic t_one;
    for (int h = 0; h < 2; h++)
    begin
        @(posedge core_clk);
        halt <= !h[0];
        bus(1, `O8T_IDX_CTL, 8'h13);
        wt(64);
        chk(`O8T_IDX_CTL, 8'h03 - 8'(h), 2'h0);
        bus(1, `O8T_IDX_CTL, 8'h00);
    end
    wt(2);
    `CHK("irq", 1'b0, irq)
    bus(1, `O8T_IDX_IMSK, 8'h01);
    wt(2);
    `CHK("irq", 1'b1, irq)
    bus(1, `O8T_IDX_IFLG, 8'h01);
    wt(2);
    `CHK("irq", 1'b0, irq)
    $display("end oneshot");
endtask
task automatic t_div;
    int e;
    bus(1, `O8T_IDX_CMP, 8'hff);
    for (int d = 0; d < 9; d++)
    begin
        e = d > 5 ? 0 : 32 >> d;
        bus(1, `O8T_IDX_FEED, 8'({d[2:0], d < 8}));
        bus(1, `O8T_IDX_CTL, 8'h11);
        wt(256);
        bus(1, `O8T_IDX_CTL, 8'h00);
        bus(0, `O8T_IDX_CNT, 8'h00);
        `CHK("ticks", 1'b1, rb + 1 >= e && rb <= e + (e > 0))
    end
    $display("end divide");
endtask
task automatic t_pwm;
    int h;
    bus(1, `O8T_IDX_FEED, 8'h01);
    bus(1, `O8T_IDX_CMP, 8'h03);
    for (int n = 1; n < 5; n += 3)
    begin
        bus(1, `O8T_IDX_CTL, 8'h00);
        bus(1, `O8T_IDX_DUTY, 8'(n));
        bus(1, `O8T_IDX_CTL, 8'h11);
        h = 0;
        repeat (256)
        begin
            @(negedge core_clk);
            h += int'(pwm === 1'b1);
        end
        `CHK("pwm", 1'b1, n > 3 ? h == 0 : h > 120 && h < 136)
    end
    $display("end pwm");
endtask
task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
initial
begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs;
    t_rep;
    t_one;
    t_div;
    t_pwm;
    print_verdict;
end
initial
begin
    #2000000;
    fails++;
    print_verdict;
end
endmodule // o8t_timer_test
`default_nettype wire
